// *** hw/pin_sync3.v ***
`timescale 1ns/100ps
`default_nettype none

module pin_sync3 (
  input wire clock,
  input wire rst,
  input wire pin,
  output wire level
);

  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  reg level_ff;

  // A change is taken only once the second and third stages agree.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
      end
    end
  end

  assign level = level_ff;

endmodule

`default_nettype wire

// *** hw/prescaler_taps.v ***
`timescale 1ns/100ps
`default_nettype none

module prescaler_taps #(
  parameter WIDTH = 10
) (
  input wire clock,
  input wire rst,
  output wire tick_8,
  output wire tick_64,
  output wire tick_256,
  output wire tick_1024
);

  reg [WIDTH-1:0] div_ff;

  // Free running, so a newly selected tap may fire early on its first period.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      div_ff <= {WIDTH{1'b0}};
    end else begin
      div_ff <= div_ff + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign tick_8 = &div_ff[2:0];
  assign tick_64 = &div_ff[5:0];
  assign tick_256 = &div_ff[7:0];
  assign tick_1024 = &div_ff[9:0];

endmodule

`default_nettype wire

// *** hw/timer16_capture_compare.v ***
`timescale 1ns/100ps
`default_nettype none
`include "timer16_regs.vh"

module timer16_capture_compare (
  input wire clock,
  input wire rst,
  input wire [7:0] addr,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] wdata,
  output wire [7:0] rdata,
  input wire capture_input_pin,
  input wire external_count_pin,
  input wire comparator_out,
  input wire capture_from_comparator,
  input wire global_irq_enable,
  input wire [3:0] irq_ack,
  output wire [3:0] irq_req,
  output wire compare_output_pin_a,
  output wire compare_output_pin_b
);

  reg [7:0] ctrl_a_ff;
  reg [7:0] ctrl_b_ff;
  reg [7:0] mask_ff;
  reg [7:0] temp_ff;
  reg [15:0] count_ff;
  reg [15:0] cmp_a_ff;
  reg [15:0] cmp_b_ff;
  reg [15:0] capture_ff;
  reg down_ff;
  reg block_ff;
  reg flag_cap_ff;
  reg flag_a_ff;
  reg flag_b_ff;
  reg flag_ov_ff;
  reg [3:0] filt_ff;
  reg filt_out_ff;
  reg cap_prev_ff;
  reg ext_prev_ff;
  reg out_a_ff;
  reg out_b_ff;
  reg [7:0] rdata_ff;
  reg [3:0] irq_ff;
  reg [7:0] nxt_rdata;
  reg tick;

  wire pin_cap_level;
  wire pin_ext_level;
  wire tick_8;
  wire tick_64;
  wire tick_256;
  wire tick_1024;

  function [15:0] top_of;
    input [3:0] m;
    input [15:0] ocra;
    input [15:0] icr;
    begin
      case (m)
        4'h1, 4'h5: top_of = `TOP_8BIT;
        4'h2, 4'h6: top_of = `TOP_9BIT;
        4'h3, 4'h7: top_of = `TOP_10BIT;
        4'h4, 4'h9, 4'hb, 4'hf: top_of = ocra;
        4'h8, 4'ha, 4'hc, 4'he: top_of = icr;
        default: top_of = `TOP_MAX;
      endcase
    end
  endfunction

  // Non-PWM match effect on an output, chosen by the output mode bits.
  function match_level;
    input [1:0] com;
    input pin;
    begin
      case (com)
        2'h1: match_level = ~pin;
        2'h2: match_level = 1'b0;
        2'h3: match_level = 1'b1;
        default: match_level = pin;
      endcase
    end
  endfunction

  wire [3:0] waveform_mode = {ctrl_b_ff[4:3], ctrl_a_ff[1:0]};
  wire [2:0] clock_source_select = ctrl_b_ff[2:0];
  wire capture_filter_enable = ctrl_b_ff[`BIT_FILTER_EN];
  wire capture_edge_select = ctrl_b_ff[`BIT_EDGE_SEL];
  wire [1:0] com_a = ctrl_a_ff[7:6];
  wire [1:0] com_b = ctrl_a_ff[5:4];
  wire [15:0] top_value = top_of(waveform_mode, cmp_a_ff, capture_ff);
  wire pwm = !(waveform_mode == 4'h0 || waveform_mode == 4'h4 || waveform_mode[3:1] == 3'h6);
  wire phase = !waveform_mode[2] && (waveform_mode[3] || |waveform_mode[1:0]);
  wire icr_top = waveform_mode[3] && !waveform_mode[0];

  pin_sync3 u_cap_sync (
    .clock(clock),
    .rst(rst),
    .pin(capture_input_pin),
    .level(pin_cap_level)
  );

  pin_sync3 u_ext_sync (
    .clock(clock),
    .rst(rst),
    .pin(external_count_pin),
    .level(pin_ext_level)
  );

  prescaler_taps #(.WIDTH(10)) u_prescaler (
    .clock(clock),
    .rst(rst),
    .tick_8(tick_8),
    .tick_64(tick_64),
    .tick_256(tick_256),
    .tick_1024(tick_1024)
  );

  // The pin level is used regardless of the pin's direction elsewhere.
  always @* begin
    case (clock_source_select)
      `CS_DIV1: tick = 1'b1;
      `CS_DIV8: tick = tick_8;
      `CS_DIV64: tick = tick_64;
      `CS_DIV256: tick = tick_256;
      `CS_DIV1024: tick = tick_1024;
      `CS_EXT_FALL: tick = ext_prev_ff & ~pin_ext_level;
      `CS_EXT_RISE: tick = ~ext_prev_ff & pin_ext_level;
      default: tick = 1'b0;
    endcase
  end

  wire cpu_wr = wr_en;
  wire wr_count = cpu_wr && addr == `ADDR_COUNT_LO;
  wire wr_flags = cpu_wr && addr == `ADDR_IRQ_FLAGS;
  wire force_a = cpu_wr && addr == `ADDR_CONTROL_C && wdata[`BIT_FORCE_A] && !pwm;
  wire force_b = cpu_wr && addr == `ADDR_CONTROL_C && wdata[`BIT_FORCE_B] && !pwm;

  wire cap_src = capture_from_comparator ? comparator_out : pin_cap_level;
  wire cap_level = capture_filter_enable ? filt_out_ff : cap_src;
  wire cap_edge = capture_edge_select ? (cap_level & ~cap_prev_ff)
                                      : (~cap_level & cap_prev_ff);
  wire cap_event = cap_edge && !icr_top;
  wire at_top = tick && count_ff == top_value;
  wire match_a = tick && !block_ff && count_ff == cmp_a_ff;
  wire match_b = tick && !block_ff && count_ff == cmp_b_ff;
  wire bottom_wrap = at_top && pwm && !phase;
  wire ov_event = phase ? (tick && down_ff && count_ff == 16'h0000)
                : (pwm ? at_top : (tick && count_ff == `TOP_MAX));
  wire cap_flag_event = cap_event || (icr_top && at_top);

  // Filter output moves only once all samples in the window agree.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      filt_ff <= 4'h0;
      filt_out_ff <= 1'b0;
      cap_prev_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
    end else begin
      filt_ff <= {filt_ff[`FILTER_SAMPLES-2:0], cap_src};
      if (&filt_ff) begin
        filt_out_ff <= 1'b1;
      end else if (~|filt_ff) begin
        filt_out_ff <= 1'b0;
      end
      cap_prev_ff <= cap_level;
      ext_prev_ff <= pin_ext_level;
    end
  end

  // A CPU write to the counter wins over counting in the same cycle.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      count_ff <= 16'h0000;
      down_ff <= 1'b0;
      block_ff <= 1'b0;
    end else if (wr_count) begin
      count_ff <= {temp_ff, wdata};
      block_ff <= 1'b1;
    end else if (tick) begin
      block_ff <= 1'b0;
      if (phase) begin
        if (!down_ff) begin
          if (count_ff >= top_value) begin
            down_ff <= 1'b1;
            count_ff <= count_ff - 16'h0001;
          end else begin
            count_ff <= count_ff + 16'h0001;
          end
        end else if (count_ff == 16'h0000) begin
          down_ff <= 1'b0;
          count_ff <= count_ff + 16'h0001;
        end else begin
          count_ff <= count_ff - 16'h0001;
        end
      end else if (count_ff == top_value) begin
        count_ff <= 16'h0000;
      end else begin
        count_ff <= count_ff + 16'h0001;
      end
    end
  end

  // Forced strobes drive the output like the counted non-PWM match; the strobe is checked first.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      out_a_ff <= 1'b0;
      out_b_ff <= 1'b0;
    end else begin
      if (force_a) begin
        out_a_ff <= match_level(com_a, out_a_ff);
      end else if (match_a && !pwm) begin
        out_a_ff <= match_level(com_a, out_a_ff);
      end else if (match_a && com_a[1]) begin
        out_a_ff <= (phase && down_ff) ? ~com_a[0] : com_a[0];
      end else if (bottom_wrap && com_a[1]) begin
        out_a_ff <= ~com_a[0];
      end
      if (force_b) begin
        out_b_ff <= match_level(com_b, out_b_ff);
      end else if (match_b && !pwm) begin
        out_b_ff <= match_level(com_b, out_b_ff);
      end else if (match_b && com_b[1]) begin
        out_b_ff <= (phase && down_ff) ? ~com_b[0] : com_b[0];
      end else if (bottom_wrap && com_b[1]) begin
        out_b_ff <= ~com_b[0];
      end
    end
  end

  // Setting beats clearing so an event in the clearing cycle is kept.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      flag_cap_ff <= 1'b0;
      flag_a_ff <= 1'b0;
      flag_b_ff <= 1'b0;
      flag_ov_ff <= 1'b0;
    end else begin
      if (cap_flag_event) begin
        flag_cap_ff <= 1'b1;
      end else if ((wr_flags && wdata[`BIT_CAPTURE]) || irq_ack[3]) begin
        flag_cap_ff <= 1'b0;
      end
      if (match_a) begin
        flag_a_ff <= 1'b1;
      end else if ((wr_flags && wdata[`BIT_MATCH_A]) || irq_ack[1]) begin
        flag_a_ff <= 1'b0;
      end
      if (match_b) begin
        flag_b_ff <= 1'b1;
      end else if ((wr_flags && wdata[`BIT_MATCH_B]) || irq_ack[2]) begin
        flag_b_ff <= 1'b0;
      end
      if (ov_event) begin
        flag_ov_ff <= 1'b1;
      end else if ((wr_flags && wdata[`BIT_OVERFLOW]) || irq_ack[0]) begin
        flag_ov_ff <= 1'b0;
      end
    end
  end

  // Control, compare and capture registers with the shared high byte latch.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_a_ff <= `CTRL_A_RESET;
      ctrl_b_ff <= `CTRL_B_RESET;
      mask_ff <= `MASK_RESET;
      temp_ff <= 8'h00;
      cmp_a_ff <= 16'h0000;
      cmp_b_ff <= 16'h0000;
      capture_ff <= 16'h0000;
    end else begin
      if (cpu_wr) begin
        case (addr)
          `ADDR_CONTROL_A: ctrl_a_ff <= wdata;
          `ADDR_CONTROL_B: ctrl_b_ff <= wdata & `CTRL_B_WRITE_MASK;
          `ADDR_IRQ_MASK: mask_ff <= wdata & `MASK_WRITE_MASK;
          `ADDR_COUNT_HI, `ADDR_CAPTURE_HI, `ADDR_CMP_A_HI, `ADDR_CMP_B_HI: begin
            temp_ff <= wdata;
          end
          `ADDR_CMP_A_LO: cmp_a_ff <= {temp_ff, wdata};
          `ADDR_CMP_B_LO: cmp_b_ff <= {temp_ff, wdata};
          default: ;
        endcase
      end else if (rd_en) begin
        case (addr)
          `ADDR_COUNT_LO: temp_ff <= count_ff[15:8];
          `ADDR_CAPTURE_LO: temp_ff <= capture_ff[15:8];
          `ADDR_CMP_A_LO: temp_ff <= cmp_a_ff[15:8];
          `ADDR_CMP_B_LO: temp_ff <= cmp_b_ff[15:8];
          default: ;
        endcase
      end
      if (cpu_wr && addr == `ADDR_CAPTURE_LO) begin
        capture_ff <= {temp_ff, wdata};
      end else if (cap_event) begin
        capture_ff <= count_ff;
      end
    end
  end

  // Force strobes and reserved bits read as zero.
  always @* begin
    case (addr)
      `ADDR_CONTROL_A: nxt_rdata = ctrl_a_ff;
      `ADDR_CONTROL_B: nxt_rdata = ctrl_b_ff;
      `ADDR_CONTROL_C: nxt_rdata = 8'h00;
      `ADDR_COUNT_LO: nxt_rdata = count_ff[7:0];
      `ADDR_CAPTURE_LO: nxt_rdata = capture_ff[7:0];
      `ADDR_CMP_A_LO: nxt_rdata = cmp_a_ff[7:0];
      `ADDR_CMP_B_LO: nxt_rdata = cmp_b_ff[7:0];
      `ADDR_COUNT_HI, `ADDR_CAPTURE_HI, `ADDR_CMP_A_HI, `ADDR_CMP_B_HI: begin
        nxt_rdata = temp_ff;
      end
      `ADDR_IRQ_MASK: nxt_rdata = mask_ff;
      `ADDR_IRQ_FLAGS: nxt_rdata = {2'h0, flag_cap_ff, 2'h0, flag_b_ff, flag_a_ff, flag_ov_ff};
      default: nxt_rdata = 8'h00;
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
      irq_ff <= 4'h0;
    end else begin
      if (rd_en) begin
        rdata_ff <= nxt_rdata;
      end
      irq_ff <= {flag_cap_ff & mask_ff[`BIT_CAPTURE],
                 flag_b_ff & mask_ff[`BIT_MATCH_B],
                 flag_a_ff & mask_ff[`BIT_MATCH_A],
                 flag_ov_ff & mask_ff[`BIT_OVERFLOW]} & {4{global_irq_enable}};
    end
  end

  assign rdata = rdata_ff;
  assign irq_req = irq_ff;
  assign compare_output_pin_a = out_a_ff;
  assign compare_output_pin_b = out_b_ff;

endmodule

`default_nettype wire

// *** hw/timer16_regs.vh ***
`ifndef TIMER16_REGS_VH
`define TIMER16_REGS_VH

`define ADDR_CONTROL_A 8'h80
`define ADDR_CONTROL_B 8'h81
`define ADDR_CONTROL_C 8'h82
`define ADDR_COUNT_LO 8'h84
`define ADDR_COUNT_HI 8'h85
`define ADDR_CAPTURE_LO 8'h86
`define ADDR_CAPTURE_HI 8'h87
`define ADDR_CMP_A_LO 8'h88
`define ADDR_CMP_A_HI 8'h89
`define ADDR_CMP_B_LO 8'h8a
`define ADDR_CMP_B_HI 8'h8b
`define ADDR_IRQ_MASK 8'h6f
`define ADDR_IRQ_FLAGS 8'h36

`define CTRL_A_RESET 8'h00
`define CTRL_B_RESET 8'h00
`define MASK_RESET 8'h00
`define CTRL_B_WRITE_MASK 8'hdf
`define MASK_WRITE_MASK 8'h27

`define BIT_FILTER_EN 7
`define BIT_EDGE_SEL 6
`define BIT_FORCE_A 7
`define BIT_FORCE_B 6
`define BIT_CAPTURE 5
`define BIT_MATCH_B 2
`define BIT_MATCH_A 1
`define BIT_OVERFLOW 0

`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7

`define FILTER_SAMPLES 4
`define TOP_MAX 16'hffff
`define TOP_8BIT 16'h00ff
`define TOP_9BIT 16'h01ff
`define TOP_10BIT 16'h03ff

`endif

// *** testbench/cpu_bus_model.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "timer16_regs.vh"
module cpu_bus_model (
  input wire clock,
  output logic [7:0] addr,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] wdata,
  input wire [7:0] rdata,
  output logic [3:0] irq_ack
);
  initial begin
    addr = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wdata = 8'h00;
    irq_ack = 4'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    addr = a;
    wdata = a == `ADDR_CONTROL_B ? d & `CTRL_B_WRITE_MASK : d;
    wr_en = 1'b1;
    @(negedge clock);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    addr = a;
    rd_en = 1'b1;
    @(negedge clock);
    rd_en = 1'b0;
    d = rdata;
  endtask
  // The acknowledge pulse stands in for the vector fetch.
  task automatic ack(input int k);
    @(negedge clock);
    irq_ack[k] = 1'b1;
    @(negedge clock);
    irq_ack = 4'h0;
  endtask
endmodule
`default_nettype wire

// *** testbench/timer16_capture_compare_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "timer16_regs.vh"
module timer16_capture_compare_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic capture_input_pin = 1'b0, external_count_pin = 1'b0;
  logic comparator_out = 1'b0, capture_from_comparator = 1'b0, global_irq_enable = 1'b1;
  wire [7:0] addr, wdata, rdata;
  wire wr_en, rd_en, compare_output_pin_a, compare_output_pin_b;
  wire [3:0] irq_ack, irq_req;
  int fails = 0;
  int comparisons = 0;
  always #50 clock = ~clock;
  timer16_capture_compare i_timer16_capture_compare (.clock, .rst, .addr, .wr_en, .rd_en,
    .wdata, .rdata, .capture_input_pin, .external_count_pin, .comparator_out,
    .capture_from_comparator, .global_irq_enable, .irq_ack, .irq_req,
    .compare_output_pin_a, .compare_output_pin_b);
  cpu_bus_model i_cpu_bus_model (.clock, .addr, .wr_en, .rd_en, .wdata, .rdata, .irq_ack);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    i_cpu_bus_model.wr(a, d);
  endtask
  task automatic r(input logic [7:0] a, output logic [7:0] d);
    i_cpu_bus_model.rd(a, d);
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    w(a + 8'h01, v[15:8]);
    w(a, v[7:0]);
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    r(a, v[7:0]);
    r(a + 8'h01, v[15:8]);
  endtask
  task automatic wait_req(input int k, input int n);
    for (int i = 0; i < n && irq_req[k] !== 1'b1; i++) @(negedge clock);
    chk(irq_req[k], 1'b1);
  endtask
  task automatic t_regs;
    logic [7:0] d;
    logic [15:0] v;
    r(`ADDR_CONTROL_B, d);
    chk(d, `CTRL_B_RESET);
    w(`ADDR_CONTROL_B, 8'hf8);
    r(`ADDR_CONTROL_B, d);
    chk(d, 8'hd8);
    w(`ADDR_CONTROL_C, 8'hc0);
    r(`ADDR_CONTROL_C, d);
    chk(d, 8'h00);
    wr16(`ADDR_CMP_A_LO, 16'h1234);
    wr16(`ADDR_COUNT_LO, 16'habcd);
    rd16(`ADDR_CMP_A_LO, v);
    chk(v, 16'h1234);
    rd16(`ADDR_COUNT_LO, v);
    chk(v, 16'habcd);
    w(`ADDR_CONTROL_B, 8'h00);
    $display("regs done");
  endtask
  task automatic t_force;
    logic [7:0] d;
    w(`ADDR_IRQ_MASK, 8'h27);
    w(`ADDR_CONTROL_A, 8'hf0);
    w(`ADDR_CONTROL_C, 8'hc0);
    chk({compare_output_pin_a, compare_output_pin_b}, 2'b11);
    w(`ADDR_CONTROL_A, 8'h60);
    w(`ADDR_CONTROL_C, 8'hc0);
    chk({compare_output_pin_a, compare_output_pin_b}, 2'b00);
    r(`ADDR_IRQ_FLAGS, d);
    chk(d, 8'h00);
    chk(irq_req, 4'h0);
    $display("force done");
  endtask
  task automatic t_match;
    logic [7:0] d;
    wr16(`ADDR_CMP_A_LO, 16'h0020);
    wr16(`ADDR_COUNT_LO, 16'h0010);
    w(`ADDR_CONTROL_B, {5'h00, `CS_DIV1});
    wait_req(1, 40);
    w(`ADDR_CONTROL_B, 8'h00);
    r(`ADDR_IRQ_FLAGS, d);
    chk(d, 8'h02);
    global_irq_enable = 1'b0;
    repeat (2) @(negedge clock);
    chk(irq_req, 4'h0);
    global_irq_enable = 1'b1;
    w(`ADDR_IRQ_FLAGS, 8'h02);
    r(`ADDR_IRQ_FLAGS, d);
    chk(d, 8'h00);
    w(`ADDR_CONTROL_B, {5'h00, `CS_DIV1});
    wr16(`ADDR_COUNT_LO, 16'h0020);
    repeat (8) @(negedge clock);
    w(`ADDR_CONTROL_B, 8'h00);
    r(`ADDR_IRQ_FLAGS, d);
    chk(d[1], 1'b0);
    $display("match done");
  endtask
  task automatic t_ovf;
    logic [3:0] md [0:4] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'h1};
    logic [15:0] st [0:4] = '{16'hfff8, 16'h00f8, 16'h01f8, 16'h03f8, 16'h00f8};
    int bd [0:4] = '{20, 20, 20, 20, 300};
    for (int i = 0; i < 5; i++) begin
      w(`ADDR_CONTROL_A, {6'h00, md[i][1:0]});
      wr16(`ADDR_COUNT_LO, st[i]);
      w(`ADDR_CONTROL_B, {3'h0, md[i][3:2], `CS_DIV1});
      w(`ADDR_CONTROL_C, 8'h00);
      wait_req(0, bd[i]);
      w(`ADDR_CONTROL_B, 8'h00);
      i_cpu_bus_model.ack(0);
      repeat (2) @(negedge clock);
      chk(irq_req[0], 1'b0);
    end
    $display("overflow done");
  endtask
  task automatic t_capture;
    logic [7:0] d;
    logic [15:0] v, c;
    w(`ADDR_CONTROL_A, 8'h00);
    wr16(`ADDR_COUNT_LO, 16'h0000);
    w(`ADDR_CONTROL_B, 8'hc1);
    @(negedge clock);
    capture_input_pin = 1'b1;
    wait_req(3, 20);
    w(`ADDR_CONTROL_B, 8'hc0);
    rd16(`ADDR_CAPTURE_LO, v);
    rd16(`ADDR_COUNT_LO, c);
    chk(v >= 16'h0007 && v < c, 1'b1);
    w(`ADDR_IRQ_FLAGS, 8'h20);
    capture_input_pin = 1'b0;
    repeat (12) @(negedge clock);
    capture_input_pin = 1'b1;
    repeat (2) @(negedge clock);
    capture_input_pin = 1'b0;
    repeat (12) @(negedge clock);
    r(`ADDR_IRQ_FLAGS, d);
    chk(d[5], 1'b0);
    capture_from_comparator = 1'b1;
    comparator_out = 1'b1;
    repeat (12) @(negedge clock);
    r(`ADDR_IRQ_FLAGS, d);
    chk(d[5], 1'b1);
    w(`ADDR_IRQ_FLAGS, 8'h20);
    capture_from_comparator = 1'b0;
    comparator_out = 1'b0;
    w(`ADDR_CONTROL_B, 8'h58);
    capture_input_pin = 1'b1;
    repeat (12) @(negedge clock);
    r(`ADDR_IRQ_FLAGS, d);
    chk(d[5], 1'b0);
    wr16(`ADDR_CAPTURE_LO, 16'h0010);
    wr16(`ADDR_COUNT_LO, 16'h0000);
    w(`ADDR_CONTROL_B, 8'h59);
    wait_req(3, 30);
    w(`ADDR_CONTROL_B, 8'h00);
    $display("capture done");
  endtask
  task automatic t_ext;
    logic [15:0] v;
    for (int s = 6; s < 8; s++) begin
      wr16(`ADDR_COUNT_LO, 16'h0000);
      w(`ADDR_CONTROL_B, {5'h00, s[2:0]});
      repeat (3) begin
        external_count_pin = 1'b1;
        repeat (4) @(negedge clock);
        external_count_pin = 1'b0;
        repeat (4) @(negedge clock);
      end
      w(`ADDR_CONTROL_B, 8'h00);
      rd16(`ADDR_COUNT_LO, v);
      chk(v, 16'h0003);
    end
    $display("external done");
  endtask
  task automatic t_taps;
    int dv [0:3] = '{8, 64, 256, 1024};
    logic [15:0] v;
    for (int s = 2; s < 6; s++) begin
      wr16(`ADDR_COUNT_LO, 16'h0000);
      w(`ADDR_CONTROL_B, {5'h00, s[2:0]});
      // The window is exactly two tap periods, so the divider's phase cannot matter.
      repeat (2 * dv[s - 2] - 2) @(negedge clock);
      w(`ADDR_CONTROL_B, 8'h00);
      rd16(`ADDR_COUNT_LO, v);
      chk(v, 16'h0002);
    end
    $display("taps done");
  endtask
  task automatic complete_run;
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    t_regs;
    t_force;
    t_match;
    t_ovf;
    t_capture;
    t_ext;
    t_taps;
    complete_run;
  end
  // The whole sequence needs about 3500 cycles, so this bound leaves ample room.
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run;
  end
endmodule
`default_nettype wire

// *** testbench/timer16_checker_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "timer16_regs.vh"
module timer16_checker (
  input wire clock,
  input wire rst,
  input wire [7:0] addr,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] wdata,
  input wire [7:0] rdata,
  input wire global_irq_enable,
  input wire [3:0] irq_ack,
  input wire [3:0] irq_req,
  input wire compare_output_pin_a,
  input wire compare_output_pin_b
);
  logic [7:0] ca_ff, cb_ff, mk_ff;
  wire [3:0] mode = {cb_ff[4:3], ca_ff[1:0]};
  // Forced matches are judged only with the counter stopped, so no real match competes.
  wire calm = cb_ff[2:0] == `CS_STOP && (mode == 4'h0 || mode == 4'h4 || mode == 4'hc);
  wire [3:0] en = {mk_ff[5], mk_ff[2:0]} & {4{global_irq_enable}};
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ca_ff <= 8'h00;
      cb_ff <= 8'h00;
      mk_ff <= 8'h00;
    end else if (wr_en) begin
      if (addr == `ADDR_CONTROL_A) ca_ff <= wdata;
      if (addr == `ADDR_CONTROL_B) cb_ff <= wdata;
      if (addr == `ADDR_IRQ_MASK) mk_ff <= wdata;
    end
  end
  default clocking dc @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_force_a; wr_en && addr == `ADDR_CONTROL_C && wdata[7] && calm; endsequence
  sequence s_force_b; wr_en && addr == `ADDR_CONTROL_C && wdata[6] && calm; endsequence
  property p_set_a; s_force_a ##0 ca_ff[7:6] == 2'b11 |=> compare_output_pin_a; endproperty
  a_set_a: assert property (p_set_a) else $error("forced set missing on a");
  property p_toggle_a;
    s_force_a ##0 ca_ff[7:6] == 2'b01 |=> compare_output_pin_a != $past(compare_output_pin_a);
  endproperty
  a_toggle_a: assert property (p_toggle_a) else $error("forced toggle missing on a");
  property p_clear_b; s_force_b ##0 ca_ff[5:4] == 2'b10 |=> !compare_output_pin_b; endproperty
  a_clear_b: assert property (p_clear_b) else $error("forced clear missing on b");
  property p_force_quiet; s_force_a ##0 !irq_req[1] |-> ##2 !irq_req[1]; endproperty
  a_force_quiet: assert property (p_force_quiet) else $error("forced match raised request");
  property p_ctrl_c_zero; rd_en && addr == `ADDR_CONTROL_C |=> rdata == 8'h00; endproperty
  a_ctrl_c_zero: assert property (p_ctrl_c_zero) else $error("force bits read nonzero");
  property p_reserved_zero; rd_en && addr == `ADDR_CONTROL_B |=> !rdata[5]; endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read one");
  property p_req_gated; |irq_req |-> (irq_req & ~$past(en)) == 4'h0; endproperty
  a_req_gated: assert property (p_req_gated) else $error("request without enable");
  property p_flag_clear;
    (irq_ack[1] || wr_en && addr == `ADDR_IRQ_FLAGS && wdata[1]) && calm |-> ##2 !irq_req[1];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("match flag not cleared");
endmodule
bind timer16_capture_compare timer16_checker i_timer16_checker (.clock, .rst, .addr, .wr_en,
  .rd_en, .wdata, .rdata, .global_irq_enable, .irq_ack, .irq_req, .compare_output_pin_a,
  .compare_output_pin_b);
`default_nettype wire
